/* rxf_regs.vh */
// Purpose: Constants for the receive address filter control block.
// Assumes: 32-bit register port, byte offsets as printed.
// Notes:   Filter memory holds 256 words of 18 bits.
`ifndef RXF_REGS_VH
`define RXF_REGS_VH
`define RXF_CTRL_OFS      8'h48
`define RXF_DATA_OFS      8'h4C
`define RXF_CTRL_RST      32'h00000000
`define RXF_BIT_EN        31
`define RXF_BIT_BCAST     30
`define RXF_BIT_MCAST     29
`define RXF_BIT_UCAST     28
`define RXF_BIT_EXACT     27
`define RXF_TPL_HI        26
`define RXF_TPL_LO        23
`define RXF_BIT_ARP       22
`define RXF_BIT_MHASH     21
`define RXF_BIT_UHASH     20
`define RXF_BIT_ULM       19
`define RXF_PTR_HI        9
`define RXF_CTRL_MASK     32'hFFF803FF
`define RXF_IDX_EXACT0    10'h000
`define RXF_IDX_EXACT1    10'h002
`define RXF_IDX_EXACT2    10'h004
`define RXF_IDX_CNT10     10'h006
`define RXF_IDX_CNT32     10'h008
`define RXF_IDX_WAKE0     10'h00A
`define RXF_IDX_WAKE1     10'h00C
`define RXF_IDX_WAKE2     10'h00E
`define RXF_IDX_MEM_BASE  10'h200
`define RXF_ARP_TYPE      16'h0806
`endif

/* rxf_filter.v */
// Purpose: Receive address filter control register, indirect filter
//          registers, filter memory and per-frame accept decision.
// Assumes: Frame bytes arrive one per cycle with a start marker; the MAC
//          supplies destination class, hash index and end-of-header strobe.
// Notes:   The decision is presented one cycle after frm_done.
//
// Our own choice: the strobed register port.
`include "rxf_regs.vh"

module rxf_filter (
  // Clock and reset
  input  wire        sys_clk,
  input  wire        arst_n,
  input  wire        clk_en,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  // Receive frame path
  input  wire        frm_start,
  input  wire        frm_byte_vld,
  input  wire [7:0]  frm_byte,
  input  wire        frm_done,
  input  wire        frm_is_bcast,
  input  wire        frm_is_mcast,
  input  wire        frm_node_match,
  input  wire [8:0]  frm_crc_idx,
  // Decision
  output reg         frm_decide,
  output reg         frm_accept
);

  // ==========================================================================
  // Reset release
  reg        rst_s1_q;
  reg        rst_n_q;

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // ==========================================================================
  // Register storage
  reg [31:0] ctrl_q;
  reg [47:0] exact_q;
  reg [47:0] wake_q;
  reg [6:0]  cnt0_q;
  reg [6:0]  cnt1_q;
  reg [6:0]  cnt2_q;
  reg [6:0]  cnt3_q;
  reg [17:0] mem [0:255];
  reg [17:0] data_rd;

  wire [9:0] ptr      = ctrl_q[`RXF_PTR_HI:0];
  wire       ptr_mem  = ptr[9];
  wire [7:0] mem_word = ptr[8:1];
  wire       wr_ctrl  = reg_wr && (reg_addr == `RXF_CTRL_OFS);
  wire       wr_data  = reg_wr && (reg_addr == `RXF_DATA_OFS);

  always @* begin
    data_rd = 18'h00000;
    if (ptr_mem) begin
      data_rd = mem[mem_word];
    end else begin
      case (ptr)
        `RXF_IDX_EXACT0: data_rd = {2'b00, exact_q[15:0]};
        `RXF_IDX_EXACT1: data_rd = {2'b00, exact_q[31:16]};
        `RXF_IDX_EXACT2: data_rd = {2'b00, exact_q[47:32]};
        `RXF_IDX_CNT10:  data_rd = {2'b00, 1'b0, cnt1_q, 1'b0, cnt0_q};
        `RXF_IDX_CNT32:  data_rd = {2'b00, 1'b0, cnt3_q, 1'b0, cnt2_q};
        `RXF_IDX_WAKE0:  data_rd = {2'b00, wake_q[15:0]};
        `RXF_IDX_WAKE1:  data_rd = {2'b00, wake_q[31:16]};
        `RXF_IDX_WAKE2:  data_rd = {2'b00, wake_q[47:32]};
        default:         data_rd = 18'h00000;
      endcase
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q  <= `RXF_CTRL_RST;
      exact_q <= 48'h000000000000;
      wake_q  <= 48'h000000000000;
      cnt0_q  <= 7'h00;
      cnt1_q  <= 7'h00;
      cnt2_q  <= 7'h00;
      cnt3_q  <= 7'h00;
    end else if (!rst_n_q) begin
      ctrl_q  <= `RXF_CTRL_RST;
      exact_q <= 48'h000000000000;
      wake_q  <= 48'h000000000000;
      cnt0_q  <= 7'h00;
      cnt1_q  <= 7'h00;
      cnt2_q  <= 7'h00;
      cnt3_q  <= 7'h00;
    end else if (clk_en) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata & `RXF_CTRL_MASK;
      end
      if (wr_data && !ptr_mem) begin
        case (ptr)
          `RXF_IDX_EXACT0: exact_q[15:0]  <= reg_wdata[15:0];
          `RXF_IDX_EXACT1: exact_q[31:16] <= reg_wdata[15:0];
          `RXF_IDX_EXACT2: exact_q[47:32] <= reg_wdata[15:0];
          `RXF_IDX_CNT10: begin
            cnt0_q <= reg_wdata[6:0];
            cnt1_q <= reg_wdata[14:8];
          end
          `RXF_IDX_CNT32: begin
            cnt2_q <= reg_wdata[6:0];
            cnt3_q <= reg_wdata[14:8];
          end
          `RXF_IDX_WAKE0: wake_q[15:0]  <= reg_wdata[15:0];
          `RXF_IDX_WAKE1: wake_q[31:16] <= reg_wdata[15:0];
          `RXF_IDX_WAKE2: wake_q[47:32] <= reg_wdata[15:0];
          default: ;
        endcase
      end
    end
  end

  // Filter memory has no reset; software initialises it.
  always @(posedge sys_clk) begin
    if (clk_en && rst_n_q && wr_data && ptr_mem) begin
      mem[mem_word] <= reg_wdata[17:0];
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      if (reg_rd && reg_addr == `RXF_CTRL_OFS) begin
        reg_rdata <= ctrl_q;
      end else if (reg_rd && reg_addr == `RXF_DATA_OFS) begin
        reg_rdata <= {14'h0000, data_rd};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // ==========================================================================
  // Frame header capture
  // Byte positions 0..5 are the destination, 12..13 the type field.
  reg [7:0]  pos_q;
  reg [47:0] da_q;
  reg [15:0] type_q;
  reg [3:0]  tpl_ok_q;
  wire       pos_sat = (pos_q == 8'hFF);
  wire [7:0] pos     = frm_start ? 8'h00 : pos_q;

  // Template words: buffers 0/1 interleave from word 64, 2/3 from word 128.
  // Each word holds two frame bytes with their mask bits.
  reg  [7:0] tpl_word [0:3];
  reg  [6:0] tpl_len  [0:3];
  reg        tpl_byte_ok [0:3];
  reg [17:0] tw;
  integer    k;
  // Separate loop index for the clocked process, so no variable has two drivers.
  integer    j;

  always @* begin
    tpl_len[0] = cnt0_q;
    tpl_len[1] = cnt1_q;
    tpl_len[2] = cnt2_q;
    tpl_len[3] = cnt3_q;
    tw = 18'h00000;
    for (k = 0; k < 4; k = k + 1) begin
      if (k < 2) begin
        tpl_word[k] = 8'h40 + {1'b0, pos[6:1], 1'b0} + k[7:0];
      end else begin
        tpl_word[k] = 8'h80 + {1'b0, pos[6:1], 1'b0} + k[7:0] - 8'h02;
      end
      tw = mem[tpl_word[k]];
      if (pos[0]) begin
        tpl_byte_ok[k] = tw[17] || (tw[15:8] == frm_byte);
      end else begin
        tpl_byte_ok[k] = tw[16] || (tw[7:0] == frm_byte);
      end
    end
  end

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q    <= 8'h00;
      da_q     <= 48'h000000000000;
      type_q   <= 16'h0000;
      tpl_ok_q <= 4'h0;
    end else if (!rst_n_q) begin
      pos_q    <= 8'h00;
      tpl_ok_q <= 4'h0;
    end else if (clk_en) begin
      if (frm_start) begin
        tpl_ok_q <= 4'hF;
      end
      if (frm_byte_vld) begin
        if (!pos_sat) begin
          pos_q <= pos + 8'h01;
        end
        if (pos < 8'd6) begin
          da_q[pos[2:0]*8 +: 8] <= frm_byte;
        end
        if (pos == 8'd12) begin
          type_q[15:8] <= frm_byte;
        end
        if (pos == 8'd13) begin
          type_q[7:0] <= frm_byte;
        end
        for (j = 0; j < 4; j = j + 1) begin
          if ({1'b0, pos} < {2'b00, tpl_len[j]} && !tpl_byte_ok[j]) begin
            tpl_ok_q[j] <= 1'b0;
          end
        end
      end else if (frm_start) begin
        pos_q <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Accept decision
  reg  [17:0] hash_word;
  reg         hash_hit;
  reg         exact_hit;
  reg  [47:0] cmp_mask;
  reg         is_ucast;

  always @* begin
    hash_word = mem[{3'b000, frm_crc_idx[8:5], 1'b0} + {7'h00, frm_crc_idx[4]}];
    hash_hit  = hash_word[frm_crc_idx[3:0]];
    cmp_mask  = 48'hFFFFFFFFFFFF;
    if (ctrl_q[`RXF_BIT_ULM]) begin
      cmp_mask[6] = 1'b0;
    end
    exact_hit = ((da_q ^ exact_q) & cmp_mask) == 48'h000000000000;
    is_ucast  = !frm_is_bcast && !frm_is_mcast;
  end

  wire acc_bcast = frm_is_bcast && ctrl_q[`RXF_BIT_BCAST];
  wire acc_mcast = frm_is_mcast && !frm_is_bcast &&
                   (ctrl_q[`RXF_BIT_MCAST] ||
                    (ctrl_q[`RXF_BIT_MHASH] && hash_hit));
  wire acc_ucast = is_ucast && (ctrl_q[`RXF_BIT_UCAST] || frm_node_match ||
                   (ctrl_q[`RXF_BIT_UHASH] && hash_hit));
  wire acc_exact = ctrl_q[`RXF_BIT_EXACT] && exact_hit;
  wire acc_tpl   = |(ctrl_q[`RXF_TPL_HI:`RXF_TPL_LO] & tpl_ok_q);
  wire acc_arp   = ctrl_q[`RXF_BIT_ARP] && (type_q == `RXF_ARP_TYPE);
  // A broadcast frame is refused outright unless broadcasts are allowed,
  // whichever other criterion it would meet.
  wire bcast_ok  = !frm_is_bcast || ctrl_q[`RXF_BIT_BCAST];

  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      frm_decide <= 1'b0;
      frm_accept <= 1'b0;
    end else if (!rst_n_q) begin
      frm_decide <= 1'b0;
      frm_accept <= 1'b0;
    end else if (clk_en) begin
      frm_decide <= frm_done;
      if (frm_done) begin
        frm_accept <= ctrl_q[`RXF_BIT_EN] && bcast_ok &&
                      (acc_bcast || acc_mcast || acc_ucast || acc_exact || acc_tpl || acc_arp);
      end
    end
  end

endmodule // rxf_filter

/* rxf_filter_props.sv */
// Purpose: Port-level properties of the receive address filter.
// Assumes: One clock domain; control writes are seen on the register port.
// Notes:   A shadow of the control register is kept from register writes.
`include "rxf_regs.vh"
module rxf_filter_props (
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        clk_en,
  // Register port
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  // Frame path and decision
  input wire logic        frm_start,
  input wire logic        frm_byte_vld,
  input wire logic [7:0]  frm_byte,
  input wire logic        frm_done,
  input wire logic        frm_is_bcast,
  input wire logic        frm_is_mcast,
  input wire logic        frm_node_match,
  input wire logic [8:0]  frm_crc_idx,
  input wire logic        frm_decide,
  input wire logic        frm_accept
);
  logic [31:0] ctl_q;
  wire         dec_en = frm_decide && ctl_q[31];
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= 32'h0;
    end else if (clk_en && reg_wr && reg_addr == `RXF_CTRL_OFS) begin
      ctl_q <= reg_wdata;
    end
  end
  // ==========================================
  // Properties
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_ctl; clk_en && reg_wr && reg_addr == `RXF_CTRL_OFS; endsequence
  sequence s_rd_ctl; clk_en && reg_rd && reg_addr == `RXF_CTRL_OFS; endsequence
  a_decide_after_done: assert property (frm_done |=> frm_decide)
    else $error("no decision after header end");
  a_accept_holds: assert property (!frm_decide |-> $stable(frm_accept))
    else $error("accept moved without a decision");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  a_unused_zero: assert property (s_rd_ctl |=> reg_rdata[18:10] == 9'h000)
    else $error("unused control bits not zero");
  a_ctrl_readback: assert property (s_wr_ctl ##2 s_rd_ctl |=> reg_rdata == ($past(reg_wdata, 3) & `RXF_CTRL_MASK))
    else $error("control readback wrong");
  a_off_rejects: assert property (frm_decide && !ctl_q[31] |-> !frm_accept)
    else $error("frame accepted while disabled");
  a_bcast_off: assert property (frm_decide && frm_is_bcast && !ctl_q[30] |-> !frm_accept)
    else $error("broadcast accepted while barred");
  a_mcast_all: assert property (dec_en && ctl_q[29] && frm_is_mcast |-> frm_accept)
    else $error("multicast refused");
  a_ucast_all: assert property (dec_en && ctl_q[28] && !frm_is_mcast && !frm_is_bcast |-> frm_accept)
    else $error("unicast refused");
endmodule // rxf_filter_props

/* rxf_mac_model.sv */
// Purpose: Receive MAC stand-in feeding header bytes and class levels.
// Assumes: One frame at a time, started by the bench.
// Notes:   The byte lane shows inverted data between frames.
module rxf_mac_model (
  input  wire logic sys_clk,
  // Frame path
  output logic       frm_start,
  output logic       frm_byte_vld,
  output logic [7:0] frm_byte,
  output logic       frm_done,
  output logic       frm_is_bcast,
  output logic       frm_is_mcast,
  output logic       frm_node_match,
  output logic [8:0] frm_crc_idx
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {frm_start, frm_byte_vld, frm_done, frm_is_bcast, frm_is_mcast, frm_node_match} = 6'h00;
    frm_byte = 8'h00;
    frm_crc_idx = 9'h000;
  end
  // Class is {ARP type, broadcast, multicast, node match}.
  task automatic send(input [47:0] da, input [3:0] cls, input [8:0] crc);
    logic [111:0] hdr;
    integer       k;
    begin
      hdr = {da, 48'hA5C30F1E2D3C, cls[3] ? 16'h0806 : 16'h0800};
      for (k = 0; k < 14; k = k + 1) begin
        @(posedge sys_clk);
        frm_start <= (k == 0);
        frm_byte_vld <= 1'b1;
        frm_byte <= hdr[111 - 8 * k -: 8];
        {frm_is_bcast, frm_is_mcast, frm_node_match} <= cls[2:0];
        frm_crc_idx <= crc;
      end
      @(posedge sys_clk);
      {frm_start, frm_byte_vld, frm_done} <= 3'b001;
      frm_byte <= ~frm_byte;
      @(posedge sys_clk);
      frm_done <= 1'b0;
    end
  endtask
endmodule // rxf_mac_model

/* tb_top.sv */
// Purpose: Self-checking bench for the receive address filter.
// Assumes: Clock enable high except for one blocked control write; filter memory written before the first enabled frame.
// Notes:   Frames after the memory setup use hash bits that were written; the first frame, sent disabled, reads an unknown one.
`include "rxf_regs.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, arst_n, reg_wr, reg_rd, frm_start, frm_byte_vld, frm_done;
  logic        frm_is_bcast, frm_is_mcast, frm_node_match, frm_decide, frm_accept;
  logic [7:0]  reg_addr, frm_byte;
  logic [31:0] reg_wdata, reg_rdata;
  logic [8:0]  frm_crc_idx;
  logic        clk_en = 1'b1;
  integer      failures = 0, compares = 0, cyc = 0, i;
  rxf_filter dut_u (.*);
  rxf_mac_model mac_u (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ==========================================
  // Access tasks
  task automatic check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
    end
  endtask
  task automatic rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata, exp);
    end
  endtask
  task automatic mem(input [9:0] p, input [31:0] d);
    begin
      wr(`RXF_CTRL_OFS, {22'h0, p});
      wr(`RXF_DATA_OFS, d);
    end
  endtask
  task automatic frm(input [31:0] c, input [47:0] da, input [3:0] cls, input [8:0] crc, input exp);
    begin
      wr(`RXF_CTRL_OFS, c & 32'h7FFFFFFF);
      wr(`RXF_CTRL_OFS, c);
      mac_u.send(da, cls, crc);
      #1 check({30'h0, frm_decide, frm_accept}, {30'h0, 1'b1, exp});
    end
  endtask
  task automatic test_done;
    begin
      if (failures == 0 && compares > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures = failures + 1;
      test_done();
    end
  end
  // ==========================================
  // Main sequence
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, arst_n} = 43'h0;
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rd(`RXF_CTRL_OFS, `RXF_CTRL_RST);
    frm(32'h40000000, 48'hFFFFFFFFFFFF, 4'h4, 9'h1A4, 1'b0);
    wr(`RXF_CTRL_OFS, 32'h7FFFFFFF);
    rd(`RXF_CTRL_OFS, 32'h7FF803FF);
    mem(`RXF_IDX_EXACT0, 32'h0008);
    mem(`RXF_IDX_EXACT1, 32'h0717);
    mem(`RXF_IDX_EXACT2, 32'h5528);
    rd(`RXF_DATA_OFS, 32'h5528);
    mem(`RXF_IDX_CNT10, 32'h0202);
    mem(`RXF_IDX_CNT32, 32'h0202);
    rd(`RXF_DATA_OFS, 32'h0202);
    mem(`RXF_IDX_WAKE2, 32'hBEEF);
    rd(`RXF_DATA_OFS, 32'hBEEF);
    mem(10'h3FE, 32'h3A5C3);
    rd(`RXF_DATA_OFS, 32'h3A5C3);
    mem(10'h234, 32'h0020);
    for (i = 0; i < 4; i = i + 1) begin
      mem(10'h280 + 10'(i[0] * 2) + 10'(i[1] * 128), 32'h0002);
    end
    frm(32'hC0000000, 48'hFFFFFFFFFFFF, 4'h4, 9'h1A4, 1'b1);
    frm(32'hBFF80000, 48'hFFFFFFFFFFFF, 4'h4, 9'h1A5, 1'b0);
    frm(32'hA0000000, 48'h01005E000001, 4'h2, 9'h1A4, 1'b1);
    frm(32'h80200000, 48'h01005E000001, 4'h2, 9'h1A5, 1'b1);
    frm(32'h80200000, 48'h01005E000001, 4'h2, 9'h1A4, 1'b0);
    frm(32'h80000000, 48'h01005E000001, 4'h2, 9'h1A5, 1'b0);
    frm(32'h80100000, 48'h0A0B0C0D0E0F, 4'h0, 9'h1A5, 1'b1);
    frm(32'h80200000, 48'h0A0B0C0D0E0F, 4'h0, 9'h1A5, 1'b0);
    frm(32'h90000000, 48'h0A0B0C0D0E0F, 4'h0, 9'h1A4, 1'b1);
    frm(32'h80000000, 48'h0A0B0C0D0E0F, 4'h1, 9'h1A4, 1'b1);
    frm(32'h80000000, 48'h0A0B0C0D0E0F, 4'h0, 9'h1A4, 1'b0);
    frm(32'h88000000, 48'h080017072855, 4'h0, 9'h1A4, 1'b1);
    frm(32'h80000000, 48'h080017072855, 4'h0, 9'h1A4, 1'b0);
    frm(32'h88000000, 48'h480017072855, 4'h0, 9'h1A4, 1'b0);
    frm(32'h88080000, 48'h480017072855, 4'h0, 9'h1A4, 1'b1);
    frm(32'h80400000, 48'h0A0B0C0D0E0F, 4'h8, 9'h1A4, 1'b1);
    frm(32'h80000000, 48'h0A0B0C0D0E0F, 4'h8, 9'h1A4, 1'b0);
    frm(32'h87800000, 48'h0200AABBCCDD, 4'h0, 9'h1A4, 1'b1);
    frm(32'h87800000, 48'h0201AABBCCDD, 4'h0, 9'h1A4, 1'b0);
    frm(32'h80400000, 48'hFFFFFFFFFFFF, 4'hC, 9'h1A4, 1'b0);
    // A write while the clock enable is low must leave the control word alone.
    @(posedge sys_clk) clk_en <= 1'b0;
    wr(`RXF_CTRL_OFS, 32'h40000000);
    clk_en <= 1'b1;
    rd(`RXF_CTRL_OFS, 32'h80400000);
    test_done();
  end
endmodule // tb_top
bind rxf_filter rxf_filter_props props_u (.*);
